// ==== include/cct_defines.svh ====
// Constants of the 16-bit capture/compare timer
//
// Functional notes
// [RULE1] Start is asynchronous to the count pulse; first match may lag one period.
// [RULE2] Software loads both capture/compare registers with nonzero values.
// [RULE3] First compare set below counter: counter wraps through zero before matching.
// [RULE4] Software restarts the timer after lowering the first compare value.
// [RULE5] Edge during second register read still captures and sets its flag.
// [RULE6] Software stops the timer before changing the valid-edge selection.
// [RULE7] Overflow flag sets on every roll from maximum to zero, clear mode included.
// [RULE8] Capture wins over a coinciding read; that read returns undefined data.
// [RULE9] Compare write in the match period may spoil that match.
// [RULE10] Software avoids writing a compare register near its expected match.
// [RULE11] Both capture/compare flags are raised even in remote-control use.
// [RULE12] Software masks the two capture/compare interrupts in remote-control use.
// [RULE13] Input high after reset is seen as rising edge at first enable.
// [RULE14] Filtered path: same false rising edge if enabled before filter settles.
// [RULE15] Filter samples at chosen rate, changes output after four equal samples.
// [RULE16] 16-bit up-counter on count clock, optional clear on first compare match.
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

`define CCT_ADDR_W        8
`define CCT_OFF_CTRL      8'h00
`define CCT_OFF_PRM       8'h04
`define CCT_OFF_CMP0      8'h08
`define CCT_OFF_CMP1      8'h0C
`define CCT_OFF_CNT       8'h10
`define CCT_OFF_STAT      8'h14
`define CCT_OFF_MASK      8'h18

`define CCT_CTRL_CAP0     0
`define CCT_CTRL_CAP1     1
`define CCT_CTRL_MODE_LSB 2
`define CCT_CTRL_MODE_MSB 3
`define CCT_PRM_CLK_LSB   0
`define CCT_PRM_CLK_MSB   1
`define CCT_PRM_EDGE_LSB  4
`define CCT_PRM_EDGE_MSB  5
`define CCT_PRM_FILT      6

`define CCT_ST_FIRST      0
`define CCT_ST_SECOND     1
`define CCT_ST_OVF        2
`define CCT_MASK_RST      3'h7

`define CCT_CNT_ZERO      16'h0000
`define CCT_CNT_MAX       16'hFFFF
`define CCT_DIV_MASK0     8'h00
`define CCT_DIV_MASK1     8'h03
`define CCT_DIV_MASK2     8'h0F
`define CCT_DIV_MASK3     8'h3F

`define CCT_EDGE_FALL     2'h0
`define CCT_EDGE_RISE     2'h1
`define CCT_EDGE_NONE     2'h2
`define CCT_EDGE_BOTH     2'h3

`define CCT_RESP_OK       2'h0
`define CCT_RESP_SLVERR   2'h2
`define CCT_FILT_DEPTH    4

`endif

// ==== include/cct_pkg.sv ====
// Types of the 16-bit capture/compare timer
`include "cct_defines.svh"
package cct_pkg;

  typedef enum logic [1:0] {
    MODE_STOP  = 2'h0,
    MODE_FREE  = 2'h1,
    MODE_CLEAR = 2'h3,
    MODE_EVENT = 2'h2
  } cct_mode_t;

  typedef struct packed {
    logic                   sync0;
    logic                   sync1;
    cct_mode_t              mode;
    logic [1:0]             capEn;
    logic [1:0]             clkSel;
    logic [1:0]             edgeSel;
    logic                   filtSel;
    logic [7:0]             div;
    logic [15:0]            cnt;
    logic [15:0]            cmp0;
    logic [15:0]            cmp1;
    logic                   prevLvl;
    logic [2:0]             status;
    logic [2:0]             mask;
    logic                   awHeld;
    logic [`CCT_ADDR_W-1:0] awAddr;
    logic                   wHeld;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   bValid;
    logic [1:0]             bResp;
    logic                   rValid;
    logic [31:0]            rData;
    logic [1:0]             rResp;
  } cct_state_t;

endpackage : cct_pkg

// ==== include/cct_filt_if.sv ====
// Link between the timer core and its input noise filter
`timescale 1ns/1ps
interface cct_filt_if;
  logic sampleTick;
  logic pinLvl;
  logic filtLvl;

  modport core (output sampleTick, output pinLvl, input filtLvl);
  modport filt (input sampleTick, input pinLvl, output filtLvl);
endinterface : cct_filt_if

// ==== hw/cct_noise_filter.sv ====
// Sampling noise filter on the capture input
`timescale 1ns/1ps
`include "cct_defines.svh"
module cct_noise_filter #(
  parameter int DEPTH = `CCT_FILT_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstSyncN,
  cct_filt_if.filt fi
);

  typedef struct packed {
    logic [DEPTH-1:0] samp;
    logic             lvl;
  } cct_filt_state_t;

  cct_filt_state_t s;
  cct_filt_state_t next_s;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  // Output starts low, so a high pin reads as a rising edge once it has settled
  always_comb begin
    next_s = s;
    if (fi.sampleTick) begin
      next_s.samp = {s.samp[DEPTH-2:0], fi.pinLvl}; // [RULE15]
      if (&next_s.samp) begin
        next_s.lvl = 1'b1; // [RULE15] [RULE14]
      end else if (~|next_s.samp) begin
        next_s.lvl = 1'b0; // [RULE15]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fi.filtLvl = s.lvl;

endmodule : cct_noise_filter

// ==== hw/cct_timer16.sv ====
// 16-bit capture/compare timer with AXI4-Lite registers
`timescale 1ns/1ps
`include "cct_defines.svh"
module cct_timer16 (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic [`CCT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output wire logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output wire logic                   s_axi_wready,
  output wire logic [1:0]             s_axi_bresp,
  output wire logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`CCT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output wire logic                   s_axi_arready,
  output wire logic [31:0]            s_axi_rdata,
  output wire logic [1:0]             s_axi_rresp,
  output wire logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   capture_input_pin,
  output wire logic                   irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rstSync;
  logic       rstSyncN;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstSyncN = rstSync[1];

  // ----------------------------------------
  // State
  // ----------------------------------------
  cct_pkg::cct_state_t s;
  cct_pkg::cct_state_t next_s;

  cct_filt_if fiLink ();

  cct_noise_filter #(
    .DEPTH(`CCT_FILT_DEPTH)
  ) uFilter (
    .sys_clk (sys_clk),
    .rstSyncN(rstSyncN),
    .fi      (fiLink.filt)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic        awFire;
  logic        wFire;
  logic        arFire;
  logic        wrGo;
  logic [31:0] oldWord;
  logic [31:0] newWord;
  logic        wrMapped;
  logic        wrCmp0;
  logic        wrCmp1;
  logic [7:0]  divMask;
  logic        tick;
  logic        running;
  logic        lvl;
  logic        rise;
  logic        fall;
  logic        validEdge;
  logic        inc;
  logic        match0;
  logic        match1;
  logic        cap0;
  logic        cap1;
  logic        rollover;
  logic [31:0] rdWord;
  logic        rdMapped;

  assign awFire = s_axi_awvalid && s_axi_awready;
  assign wFire  = s_axi_wvalid && s_axi_wready;
  assign arFire = s_axi_arvalid && s_axi_arready;
  assign wrGo   = s.awHeld && s.wHeld;

  function automatic logic [31:0] cct_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : cct_merge

  // Register word as software sees it, for reads and for merging byte writes
  function automatic logic [32:0] cct_word(
    input cct_pkg::cct_state_t st,
    input logic [`CCT_ADDR_W-1:0] addr
  );
    logic [31:0] w;
    logic        hit;
    w   = 32'h0000_0000;
    hit = 1'b1;
    case (addr)
      `CCT_OFF_CTRL: begin
        w[`CCT_CTRL_CAP1:`CCT_CTRL_CAP0]         = st.capEn;
        w[`CCT_CTRL_MODE_MSB:`CCT_CTRL_MODE_LSB] = st.mode;
      end
      `CCT_OFF_PRM: begin
        w[`CCT_PRM_CLK_MSB:`CCT_PRM_CLK_LSB]   = st.clkSel;
        w[`CCT_PRM_EDGE_MSB:`CCT_PRM_EDGE_LSB] = st.edgeSel;
        w[`CCT_PRM_FILT]                       = st.filtSel;
      end
      `CCT_OFF_CMP0: w[15:0] = st.cmp0;
      `CCT_OFF_CMP1: w[15:0] = st.cmp1;
      `CCT_OFF_CNT:  w[15:0] = st.cnt;
      `CCT_OFF_STAT: w[2:0]  = st.status;
      `CCT_OFF_MASK: w[2:0]  = st.mask;
      default:       hit     = 1'b0;
    endcase
    return {hit, w};
  endfunction : cct_word

  assign {wrMapped, oldWord} = cct_word(s, s.awAddr);
  assign {rdMapped, rdWord}  = cct_word(s, s_axi_araddr);
  assign newWord = cct_merge(oldWord, s.wData, s.wStrb);
  assign wrCmp0  = wrGo && (s.awAddr == `CCT_OFF_CMP0);
  assign wrCmp1  = wrGo && (s.awAddr == `CCT_OFF_CMP1);

  // ----------------------------------------
  // Count clock and edges
  // ----------------------------------------
  always_comb begin
    case (s.clkSel)
      2'h0:    divMask = `CCT_DIV_MASK0;
      2'h1:    divMask = `CCT_DIV_MASK1;
      2'h2:    divMask = `CCT_DIV_MASK2;
      default: divMask = `CCT_DIV_MASK3;
    endcase
  end

  // Prescaler runs free, so a start lands anywhere inside a count period
  assign tick    = ((s.div & divMask) == 8'h00); // [RULE1]
  assign running = (s.mode != cct_pkg::MODE_STOP);

  // Previous level resets low: a pin already high looks like a rising edge
  assign lvl  = s.filtSel ? fiLink.filtLvl : s.sync1; // [RULE14]
  assign rise = lvl && !s.prevLvl; // [RULE13]
  assign fall = !lvl && s.prevLvl;

  always_comb begin
    case (s.edgeSel)
      `CCT_EDGE_FALL: validEdge = running && fall;
      `CCT_EDGE_RISE: validEdge = running && rise; // [RULE13]
      `CCT_EDGE_BOTH: validEdge = running && (rise || fall);
      default:        validEdge = 1'b0;
    endcase
  end

  assign inc = running && ((s.mode == cct_pkg::MODE_EVENT) ? validEdge : tick); // [RULE16]

  // Match is taken on the count pulse that leaves the compare value.
  // Equality only: a compare value below the counter waits for the wrap.
  // A compare write in the same cycle cancels that match.
  assign match0 = inc && !s.capEn[0] && (s.cnt == s.cmp0) && !wrCmp0; // [RULE3] [RULE9]
  assign match1 = inc && !s.capEn[1] && (s.cnt == s.cmp1) && !wrCmp1; // [RULE9]
  assign cap0   = validEdge && s.capEn[0];
  assign cap1   = validEdge && s.capEn[1];
  assign rollover = inc && (s.cnt == `CCT_CNT_MAX);

  assign fiLink.sampleTick = tick;
  assign fiLink.pinLvl     = s.sync1;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;

    // Pin synchroniser
    next_s.sync0 = capture_input_pin;
    next_s.sync1 = s.sync0;

    next_s.div = s.div + 8'h01;
    if (running) begin
      next_s.prevLvl = lvl;
    end

    // Register writes
    if (awFire) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = s_axi_awaddr;
    end
    if (wFire) begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
    end
    if (wrGo) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = wrMapped ? `CCT_RESP_OK : `CCT_RESP_SLVERR;
      case (s.awAddr)
        `CCT_OFF_CTRL: begin
          next_s.capEn = newWord[`CCT_CTRL_CAP1:`CCT_CTRL_CAP0];
          next_s.mode  = cct_pkg::cct_mode_t'(
            newWord[`CCT_CTRL_MODE_MSB:`CCT_CTRL_MODE_LSB]);
        end
        `CCT_OFF_PRM: begin
          next_s.clkSel  = newWord[`CCT_PRM_CLK_MSB:`CCT_PRM_CLK_LSB];
          next_s.edgeSel = newWord[`CCT_PRM_EDGE_MSB:`CCT_PRM_EDGE_LSB];
          next_s.filtSel = newWord[`CCT_PRM_FILT];
        end
        `CCT_OFF_CMP0: next_s.cmp0 = newWord[15:0];
        `CCT_OFF_CMP1: next_s.cmp1 = newWord[15:0];
        `CCT_OFF_STAT: next_s.status = s.status & ~newWord[2:0];
        `CCT_OFF_MASK: next_s.mask = newWord[2:0];
        default: begin
        end
      endcase
    end
    if (s.bValid && s_axi_bready) begin
      next_s.bValid = 1'b0;
    end

    // Register reads; a read that meets a capture gets the old word
    if (arFire) begin
      next_s.rValid = 1'b1;
      next_s.rData  = rdWord; // [RULE8]
      next_s.rResp  = rdMapped ? `CCT_RESP_OK : `CCT_RESP_SLVERR;
    end else if (s.rValid && s_axi_rready) begin
      next_s.rValid = 1'b0;
    end

    // Counter
    if (!running) begin
      next_s.cnt = `CCT_CNT_ZERO;
    end else if (inc) begin
      if (s.mode == cct_pkg::MODE_CLEAR && match0) begin
        next_s.cnt = `CCT_CNT_ZERO; // [RULE16]
      end else begin
        next_s.cnt = s.cnt + 16'h0001; // [RULE16] [RULE3]
      end
    end

    // Captures override a software write in the same cycle
    if (cap0) begin
      next_s.cmp0 = s.cnt; // [RULE8]
    end
    if (cap1) begin
      next_s.cmp1 = s.cnt; // [RULE5] [RULE8]
    end

    // Flags: a set beats a clear that lands in the same cycle.
    // Filter selection reaches these flags only through the pin edges it passes.
    if (match0 || cap0) begin
      next_s.status[`CCT_ST_FIRST] = 1'b1; // [RULE11]
    end
    if (match1 || cap1) begin
      next_s.status[`CCT_ST_SECOND] = 1'b1; // [RULE5] [RULE11]
    end
    if (rollover) begin
      next_s.status[`CCT_ST_OVF] = 1'b1; // [RULE7]
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s      <= '0;
      s.mask <= `CCT_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = !s.awHeld && !s.bValid;
  assign s_axi_wready  = !s.wHeld && !s.bValid;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_arready = !s.rValid;
  assign s_axi_rvalid  = s.rValid;
  assign s_axi_rdata   = s.rData;
  assign s_axi_rresp   = s.rResp;
  assign irq           = |(s.status & ~s.mask);

endmodule : cct_timer16

// ==== dv/cct_timer16_sva.sv ====
// Checker of the timer's bus and interrupt ports
`timescale 1ns/1ps
`include "cct_defines.svh"
module cct_timer16_sva (
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  input wire logic [`CCT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [`CCT_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  rd_answer_a: assert property (rdTake |=> s_axi_rvalid)
    else $error("read not answered in the next cycle");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  // Both items are parked for one cycle before the write lands
  wr_answer_a: assert property (wrTake |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write not answered in the second cycle");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel ready while answer pending");
  bad_read_a: assert property (rdTake ##0 (s_axi_araddr == 8'h40) |=> s_axi_rresp == `CCT_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  bad_write_a: assert property (wrTake ##0 (s_axi_awaddr == 8'h40) |-> ##2 s_axi_bresp == `CCT_RESP_SLVERR)
    else $error("unmapped write not refused");
  mask_all_a: assert property (wrTake ##0 (s_axi_awaddr == `CCT_OFF_MASK && s_axi_wdata[2:0] == 3'h7) |-> ##2 !irq)
    else $error("interrupt high with every source masked");
endmodule : cct_timer16_sva

bind cct_timer16 cct_timer16_sva u_cct_timer16_sva (.*);

// ==== dv/cct_pin_drv.sv ====
// Far side of the capture pin: pulled-up line with low pulses on demand
`timescale 1ns/1ps
module cct_pin_drv (
  input  wire logic       sys_clk,
  input  wire logic       trig,
  input  wire logic [7:0] lowLen,
  output logic            pin
);
  logic [7:0] left;
  // Pull-up keeps the line high through reset, the awkward case at first enable
  initial begin
    pin  = 1'b1;
    left = 8'h00;
  end
  // Pulses stay longer than four samples so the filter passes them
  always @(posedge sys_clk) begin
    if (trig) begin
      left <= lowLen;
      pin  <= 1'b0;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      pin  <= 1'b1;
    end
  end
endmodule : cct_pin_drv

// ==== dv/tb_capture_compare_timer16.sv ====
// Register-level testbench of the capture/compare timer
`timescale 1ns/1ps
`include "cct_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errTotal++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_capture_compare_timer16;
  logic sys_clk = 1'b0, reset_n = 1'b0, trig = 1'b0, pin;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int errTotal = 0, checked = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  cct_timer16 u_cct_timer16 (.sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .capture_input_pin(pin), .irq(irq));
  cct_pin_drv u_cct_pin_drv (.sys_clk(sys_clk), .trig(trig), .lowLen(8'h06), .pin(pin));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // Offers address and data together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Whole run is about 66k cycles; the long wait is one counter wrap
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      errTotal++;
      print_verdict();
    end
  end
  initial begin
    cyc(16);
    reset_n <= 1'b1;
    cyc(3);
    rd(`CCT_OFF_CTRL); `CHK("ctrl", 32'h0000_0000, d)
    rd(`CCT_OFF_MASK); `CHK("mask", 32'h0000_0007, d)
    rd(`CCT_OFF_CNT); `CHK("count", 32'h0000_0000, d)
    rd(8'h40); `CHK("bad rd", `CCT_RESP_SLVERR, rsp)
    wr(8'h40, 32'h0000_0001); `CHK("bad wr", `CCT_RESP_SLVERR, rsp)
    $display("test reset done");
    wr(`CCT_OFF_CMP0, 32'h0000_FFFF);
    wr(`CCT_OFF_PRM, 32'h0000_0010);
    wr(`CCT_OFF_CTRL, 32'h0000_0006);
    cyc(8);
    rd(`CCT_OFF_STAT); `CHK("first edge", 32'h0000_0002, d & 32'h0000_0002)
    wr(`CCT_OFF_STAT, 32'h0000_0007);
    trig <= 1'b1;
    cyc(1);
    trig <= 1'b0;
    repeat (5) rd(`CCT_OFF_CMP1);
    `CHK("cap value", 1'b1, d != 32'h0000_0000)
    rd(`CCT_OFF_STAT); `CHK("cap in read", 32'h0000_0002, d & 32'h0000_0002)
    wr(`CCT_OFF_MASK, 32'h0000_0005); `CHK("irq on", 1'b1, irq)
    wr(`CCT_OFF_MASK, 32'h0000_0007); `CHK("irq masked", 1'b0, irq)
    wr(`CCT_OFF_MASK, 32'h0000_0005);
    wr(`CCT_OFF_STAT, 32'h0000_0002); `CHK("irq cleared", 1'b0, irq)
    $display("test capture done");
    wr(`CCT_OFF_CTRL, 32'h0000_0000);
    wr(`CCT_OFF_CMP0, 32'h0000_0040);
    wr(`CCT_OFF_CMP1, 32'h0000_FFF0);
    wr(`CCT_OFF_CTRL, 32'h0000_000C);
    cyc(140);
    rd(`CCT_OFF_STAT); `CHK("match", 32'h0000_0001, d & 32'h0000_0001)
    wr(`CCT_OFF_CTRL, 32'h0000_0000);
    wr(`CCT_OFF_STAT, 32'h0000_0007);
    wr(`CCT_OFF_CTRL, 32'h0000_000C);
    cyc(40);
    // Lowered on purpose without a restart to see the wrap
    wr(`CCT_OFF_CMP0, 32'h0000_0010);
    rd(`CCT_OFF_CNT); `CHK("past new cmp", 1'b1, d > 32'h0000_0010)
    cyc(100);
    rd(`CCT_OFF_STAT); `CHK("no early match", 32'h0000_0000, d & 32'h0000_0001)
    cyc(65536);
    rd(`CCT_OFF_STAT); `CHK("wrap", 32'h0000_0005, d & 32'h0000_0005)
    // Proper way to lower the compare value: stop, write, start again
    wr(`CCT_OFF_CTRL, 32'h0000_0000);
    wr(`CCT_OFF_CMP0, 32'h0000_0008);
    wr(`CCT_OFF_STAT, 32'h0000_0007);
    wr(`CCT_OFF_CTRL, 32'h0000_000C);
    cyc(20);
    rd(`CCT_OFF_STAT); `CHK("restart match", 32'h0000_0001, d & 32'h0000_0001)
    rd(`CCT_OFF_CNT); `CHK("clear range", 1'b1, d <= 32'h0000_0008)
    $display("test compare done");
    reset_n <= 1'b0;
    cyc(4);
    reset_n <= 1'b1;
    cyc(3);
    wr(`CCT_OFF_PRM, 32'h0000_0050);
    wr(`CCT_OFF_CTRL, 32'h0000_0006);
    cyc(20);
    rd(`CCT_OFF_STAT); `CHK("filtered edge", 32'h0000_0002, d & 32'h0000_0002)
    $display("test filter done");
    // Event count on both edges: one low pulse gives two counts
    wr(`CCT_OFF_CTRL, 32'h0000_0000);
    wr(`CCT_OFF_PRM, 32'h0000_0030);
    wr(`CCT_OFF_CMP0, 32'h0000_0005);
    wr(`CCT_OFF_CMP1, 32'h0000_0001);
    wr(`CCT_OFF_CTRL, 32'h0000_0008);
    wr(`CCT_OFF_STAT, 32'h0000_0007);
    trig <= 1'b1;
    cyc(1);
    trig <= 1'b0;
    cyc(12);
    rd(`CCT_OFF_CNT); `CHK("edge count", 32'h0000_0002, d)
    rd(`CCT_OFF_STAT); `CHK("event match", 32'h0000_0002, d & 32'h0000_0003)
    $display("test event done");
    print_verdict();
  end
endmodule : tb_capture_compare_timer16
